// File: logic/cw_seq_pkg.sv
// Package of register map, field positions, reset values and timing constants for the control-word sequencer.
package cw_seq_pkg;
   // ==========================================================================
   // Register byte offsets
   localparam logic [7:0] OFF_COMMAND_WORD   = 8'h00;
   localparam logic [7:0] OFF_COMMAND_GATE   = 8'h04;
   localparam logic [7:0] OFF_SUPPLY_IND     = 8'h08;
   localparam logic [7:0] OFF_EVENT_FLAGS    = 8'h0C;
   localparam logic [7:0] OFF_SEQ_PARAMS     = 8'h10;
   localparam logic [7:0] OFF_DRIVE_STATUS   = 8'h14;
   localparam logic [7:0] OFF_DRIVE_INPUTS   = 8'h18;
   localparam logic [7:0] OFF_WDOG_LIMIT     = 8'h1C;

   // ==========================================================================
   // Command word fields
   localparam int BIT_ENABLE      = 0;
   localparam int BIT_RUN_FWD     = 1;
   localparam int BIT_JOG         = 2;
   localparam int BIT_RUN_REV     = 3;
   localparam int BIT_DIRECTION   = 4;
   localparam int BIT_RUN         = 5;
   localparam int BIT_NOT_STOP    = 6;
   localparam int BIT_AUTO        = 7;
   localparam int BIT_REF_SEL     = 8;
   localparam int BIT_JOG_REV     = 9;
   localparam int BIT_TRIP        = 12;
   localparam int BIT_RESET       = 13;
   localparam int BIT_WDOG        = 14;
   localparam int NUM_SEQ         = 8;
   localparam int EVT_MODE_CHANGED = 1;
   localparam logic [15:0] COMMAND_WORD_MAX = 16'h7FFF;

   // Sequencing parameter register layout: bit k holds sequencing function k (see seq index below),
   // bit 8 holds the reference select, bit 9 the reset request.
   localparam int SP_REF_SEL      = 8;
   localparam int SP_RESET_REQ    = 9;

   // ==========================================================================
   // Reset values
   localparam logic [15:0] RST_COMMAND_WORD = 16'h0000;
   localparam logic [9:0]  RST_SEQ_PARAMS   = 10'h000;
   localparam logic [1:0]  RST_EVENT_FLAGS  = 2'h0;

   // ==========================================================================
   // Timing
   localparam int CLK_HZ          = 100_000_000;
   localparam int WDOG_TIMEOUT_MS = 1000;
   localparam int WDOG_CYCLES     = (CLK_HZ / 1000) * WDOG_TIMEOUT_MS;

   typedef enum logic [1:0] {WD_IDLE, WD_ARMED, WD_TRIPPED} wdog_state_e;
endpackage

// File: logic/link_watchdog.sv
// Keypad link watchdog: armed and serviced by edges, trips on a missed service window.
module link_watchdog (
   // Clock and reset
   input  wire  logic        clk_sys,
   input  wire  logic        nrst,
   input  wire  logic        clk_en,
   // Control
   input  wire  logic        service,
   input  wire  logic        trip_clear,
   input  wire  logic [31:0] limit,
   // Status
   output logic              armed,
   output logic              trip
);
   import cw_seq_pkg::*;

   wdog_state_e state_q;
   logic [31:0] count_q;
   wire         expired = (count_q >= limit - 32'd1);

   // ==========================================================================
   // Watchdog state
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= WD_IDLE;
         count_q <= 32'h0000_0000;
      end else if (clk_en) begin
         case (state_q)
            WD_IDLE: begin
               count_q <= 32'h0000_0000;
               if (service) begin
                  state_q <= WD_ARMED;
               end
            end
            WD_ARMED: begin
               if (service) begin
                  count_q <= 32'h0000_0000;
               end else if (expired) begin
                  state_q <= WD_TRIPPED;
               end else begin
                  count_q <= count_q + 32'd1;
               end
            end
            WD_TRIPPED: begin
               // Disarmed; a fresh edge is only honoured after the trip is cleared.
               count_q <= 32'h0000_0000;
               if (trip_clear) begin
                  state_q <= WD_IDLE;
               end
            end
            default: state_q <= WD_IDLE;
         endcase
      end
   end

   assign armed = (state_q == WD_ARMED);
   assign trip  = (state_q == WD_TRIPPED);
endmodule

// File: logic/cw_sequencer.sv
// Control-word sequencer: APB register file, sequencing override, trips, reset edge and supply indicator.
module cw_sequencer #(
   parameter int WDOG_LIMIT_RST = cw_seq_pkg::WDOG_CYCLES
) (
   // Clock, reset, enable
   input  wire  logic        clk_sys,
   input  wire  logic        nrst,
   input  wire  logic        clk_en,
   // APB slave
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Drive status inputs
   input  wire  logic        regen_mode,
   input  wire  logic        mode_change_done,
   input  wire  logic        undervoltage_trip,
   input  wire  logic        battery_supply,
   input  wire  logic        ref_select_shared,
   // Sequencer outputs
   output logic [7:0]        seq_out,
   output logic              reference_select,
   output logic              command_word_trip,
   output logic              keypad_watchdog_trip,
   output logic              drive_reset,
   output logic              power_down_save
);
   import cw_seq_pkg::*;

   // ==========================================================================
   // Registers
   logic [15:0] cmd_q;
   logic        gate_q;
   logic        supply_q;
   logic [1:0]  evt_q;
   logic [9:0]  sp_q;
   logic [31:0] wd_limit_q;
   logic        cw_trip_q;
   logic        reset_prev_q;
   logic        wdog_prev_q;
   logic        uv_prev_q;
   logic [7:0]  seq_q;
   logic        ref_q;
   logic        rst_pulse_q;
   logic        save_q;
   logic        wd_trip_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        wd_armed;
   logic        wd_trip;

   // ==========================================================================
   // Bus decode
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction

   wire setup     = psel && !penable;
   wire wr_setup  = setup && pwrite;
   wire wr_cmd    = wr_setup && hit(paddr, OFF_COMMAND_WORD);
   wire wr_gate   = wr_setup && hit(paddr, OFF_COMMAND_GATE);
   wire wr_evt    = wr_setup && hit(paddr, OFF_EVENT_FLAGS);
   wire wr_sp     = wr_setup && hit(paddr, OFF_SEQ_PARAMS);
   wire wr_wdl    = wr_setup && hit(paddr, OFF_WDOG_LIMIT);
   wire ro_write  = wr_setup && (hit(paddr, OFF_SUPPLY_IND) || hit(paddr, OFF_DRIVE_STATUS)
                    || hit(paddr, OFF_DRIVE_INPUTS));
   wire mapped    = hit(paddr, OFF_COMMAND_WORD) || hit(paddr, OFF_COMMAND_GATE)
                    || hit(paddr, OFF_SUPPLY_IND) || hit(paddr, OFF_EVENT_FLAGS)
                    || hit(paddr, OFF_SEQ_PARAMS) || hit(paddr, OFF_DRIVE_STATUS)
                    || hit(paddr, OFF_DRIVE_INPUTS) || hit(paddr, OFF_WDOG_LIMIT);
   wire bus_err   = !mapped || ro_write;

   // ==========================================================================
   // Command word decode
   wire gated      = gate_q;
   wire seq_active = gate_q && cmd_q[BIT_AUTO];
   wire trip_bit   = gated && cmd_q[BIT_TRIP];
   wire reset_edge = gated && cmd_q[BIT_RESET] && !reset_prev_q;
   wire wdog_edge  = gated && cmd_q[BIT_WDOG] && !wdog_prev_q;
   wire uv_cleared = uv_prev_q && !undervoltage_trip;
   // Any trip reset also releases the command-word trip once bit 12 is low.
   wire trip_reset = reset_edge || sp_q[SP_RESET_REQ];

   // Sequencing functions in order 0..6 and jog reverse as element 7.
   logic [7:0] word_seq;
   logic [7:0] param_seq;
   logic [7:0] seq_d;
   assign word_seq  = {cmd_q[BIT_JOG_REV], cmd_q[6:0]};
   assign param_seq = sp_q[7:0];

   genvar g;
   generate
      for (g = 0; g < NUM_SEQ; g++) begin : g_seq
         // Bit 0 (drive enable) stays live in regeneration; the rest are ignored there.
         if (g == 0) begin : g_en
            assign seq_d[g] = seq_active ? word_seq[g] : param_seq[g];
         end else begin : g_run
            assign seq_d[g] = (seq_active && !regen_mode) ? word_seq[g] : param_seq[g];
         end
      end
   endgenerate

   // The reference value is undefined when shared; the word then simply loses priority.
   wire ref_d = (gated && !regen_mode && !ref_select_shared) ? cmd_q[BIT_REF_SEL] : sp_q[SP_REF_SEL];

   wire [31:0] rd_mux =
      hit(paddr, OFF_COMMAND_WORD) ? {16'h0000, cmd_q} :
      hit(paddr, OFF_COMMAND_GATE) ? {31'h0000_0000, gate_q} :
      hit(paddr, OFF_SUPPLY_IND)   ? {31'h0000_0000, supply_q} :
      hit(paddr, OFF_EVENT_FLAGS)  ? {30'h0000_0000, evt_q} :
      hit(paddr, OFF_SEQ_PARAMS)   ? {22'h00_0000, sp_q} :
      hit(paddr, OFF_DRIVE_STATUS) ? {27'h000_0000, wd_armed, wd_trip_q, cw_trip_q, ref_q, save_q} :
      hit(paddr, OFF_DRIVE_INPUTS) ? {24'h00_0000, seq_q} :
      hit(paddr, OFF_WDOG_LIMIT)   ? wd_limit_q : 32'h0000_0000;

   // ==========================================================================
   // APB response: no wait state, answer in the access cycle.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pready_q  <= setup;
         pslverr_q <= setup && bus_err;
         if (setup && !pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // ==========================================================================
   // Software registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmd_q      <= RST_COMMAND_WORD;
         gate_q     <= 1'b0;
         sp_q       <= RST_SEQ_PARAMS;
         wd_limit_q <= 32'(WDOG_LIMIT_RST);
      end else if (clk_en) begin
         if (wr_cmd) begin
            cmd_q <= pwdata[15:0] & COMMAND_WORD_MAX;
         end
         if (wr_gate) begin
            gate_q <= pwdata[0];
         end
         if (wr_sp) begin
            sp_q <= pwdata[9:0];
         end
         if (wr_wdl) begin
            wd_limit_q <= pwdata;
         end
      end
   end

   // ==========================================================================
   // Event flags: hardware set wins over a software write-one clear.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         evt_q <= RST_EVENT_FLAGS;
      end else if (clk_en) begin
         if (wr_evt) begin
            evt_q <= evt_q & ~pwdata[1:0];
         end
         if (mode_change_done) begin
            evt_q[EVT_MODE_CHANGED] <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Edge history, trips and outputs
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reset_prev_q <= 1'b0;
         wdog_prev_q  <= 1'b0;
         uv_prev_q    <= 1'b0;
         cw_trip_q    <= 1'b0;
         supply_q     <= 1'b0;
         seq_q        <= 8'h00;
         ref_q        <= 1'b0;
         rst_pulse_q  <= 1'b0;
         save_q       <= 1'b0;
         wd_trip_q    <= 1'b0;
      end else if (clk_en) begin
         if (gated) begin
            reset_prev_q <= cmd_q[BIT_RESET];
            wdog_prev_q  <= cmd_q[BIT_WDOG];
         end
         uv_prev_q <= undervoltage_trip;
         if (trip_bit) begin
            cw_trip_q <= 1'b1;
         end else if (trip_reset) begin
            cw_trip_q <= 1'b0;
         end
         if (uv_cleared) begin
            supply_q <= battery_supply;
         end
         save_q      <= undervoltage_trip && !uv_prev_q && !supply_q;
         seq_q       <= seq_d;
         ref_q       <= ref_d;
         rst_pulse_q <= reset_edge;
         wd_trip_q   <= wd_trip;
      end
   end

   // ==========================================================================
   // Keypad watchdog
   link_watchdog u_wdog (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .clk_en     (clk_en),
      .service    (wdog_edge),
      .trip_clear (trip_reset),
      .limit      (wd_limit_q),
      .armed      (wd_armed),
      .trip       (wd_trip)
   );

   assign prdata               = prdata_q;
   assign pready               = pready_q;
   assign pslverr              = pslverr_q;
   assign seq_out              = seq_q;
   assign reference_select     = ref_q;
   assign command_word_trip    = cw_trip_q;
   assign keypad_watchdog_trip = wd_trip_q;
   assign drive_reset          = rst_pulse_q;
   assign power_down_save      = save_q;
endmodule

// File: sim/cw_sequencer_chk.sv
// Checker of bus timing and command word decoding at the control-word sequencer ports.
module cw_sequencer_chk (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        clk_en,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // Drive side
   input wire logic        regen_mode,
   input wire logic        ref_select_shared,
   input wire logic [7:0]  seq_out,
   input wire logic        reference_select,
   input wire logic        command_word_trip,
   input wire logic        drive_reset,
   input wire logic        power_down_save
);
   import cw_seq_pkg::*;
   // ==========================================================================
   // Shadow of the command word, gate and sequencing parameter registers, kept from the bus alone.
   logic [15:0] cw_q;
   logic [7:0]  sp_q;
   logic [7:0]  exp_q;
   logic        gate_q;
   logic        prev_q;
   logic        wr;
   logic        rise;
   logic [7:0]  exp_seq;
   assign wr = psel && !penable && pwrite && clk_en;
   assign rise = gate_q && cw_q[BIT_RESET] && !prev_q;
   assign exp_seq = (gate_q && cw_q[BIT_AUTO]) ? {cw_q[BIT_JOG_REV], cw_q[6:0]} : sp_q;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cw_q <= 16'h0000;
         sp_q <= 8'h00;
         gate_q <= 1'b0;
         prev_q <= 1'b0;
         exp_q <= 8'h00;
      end else if (clk_en) begin
         if (wr && paddr == OFF_COMMAND_WORD) cw_q <= pwdata[15:0];
         if (wr && paddr == OFF_SEQ_PARAMS) sp_q <= pwdata[7:0];
         if (wr && paddr == OFF_COMMAND_GATE) gate_q <= pwdata[0];
         if (gate_q) prev_q <= cw_q[BIT_RESET];
         exp_q <= exp_seq;
      end
   end
   // ==========================================================================
   // Assertions
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   property p_ready; psel && !penable && clk_en |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_seq_en; 1 |=> seq_out[0] == exp_q[0]; endproperty
   a_seq_en: assert property (p_seq_en) else $error("drive enable wrong source");
   property p_seq_run; !regen_mode |=> seq_out[7:1] == exp_q[7:1]; endproperty
   a_seq_run: assert property (p_seq_run) else $error("sequencing bits wrong source");
   property p_ref; gate_q && !regen_mode && !ref_select_shared |=> reference_select == $past(cw_q[BIT_REF_SEL]); endproperty
   a_ref: assert property (p_ref) else $error("reference select not copied");
   property p_cw_trip; gate_q && cw_q[BIT_TRIP] |=> command_word_trip; endproperty
   a_cw_trip: assert property (p_cw_trip) else $error("trip bit not obeyed");
   property p_reset_edge; drive_reset |-> $past(rise) || $past(rise, 2); endproperty
   a_reset_edge: assert property (p_reset_edge) else $error("reset without rising edge");
   property p_save_pulse; power_down_save |=> !power_down_save; endproperty
   a_save_pulse: assert property (p_save_pulse) else $error("save pulse too long");
endmodule

bind cw_sequencer cw_sequencer_chk u_chk (.clk_sys, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .regen_mode, .ref_select_shared, .seq_out, .reference_select, .command_word_trip, .drive_reset,
   .power_down_save);

// File: sim/cw_sequencer_test.sv
// Self-checking testbench of the control-word sequencer.
module cw_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cw_seq_pkg::*;
   // Short watchdog window keeps the run brief.
   localparam int WD = 50;
   logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic regen_mode = 1'b0, mode_change_done = 1'b0, undervoltage_trip = 1'b0, battery_supply = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic [31:0] seed = 32'hf654_747b;
   logic [7:0]  seq_out;
   logic        pready, pslverr, err, reference_select, command_word_trip, keypad_watchdog_trip;
   logic        drive_reset, power_down_save;
   int          n_fail = 0, n_tests = 0, n_rst = 0, n_save = 0;

   cw_sequencer #(.WDOG_LIMIT_RST(WD)) u_cw_sequencer (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .regen_mode(regen_mode), .mode_change_done(mode_change_done),
      .undervoltage_trip(undervoltage_trip), .battery_supply(battery_supply), .ref_select_shared(1'b0),
      .seq_out(seq_out), .reference_select(reference_select), .command_word_trip(command_word_trip),
      .keypad_watchdog_trip(keypad_watchdog_trip), .drive_reset(drive_reset), .power_down_save(power_down_save));

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (drive_reset === 1'b1) n_rst++;
      if (power_down_save === 1'b1) n_save++;
   end
   // ==========================================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] exp_seq(input logic g, input logic [31:0] c, input logic [31:0] s);
      return (g && c[BIT_AUTO]) ? {c[BIT_JOG_REV], c[6:0]} : s[7:0];
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   // Request is held until the rising edge at which pready is seen high; data is taken at that edge.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic supply(input logic uv, input logic bat);
      @(posedge clk_sys);
      undervoltage_trip <= uv;
      battery_supply <= bat;
      cyc(4);
   endtask
   // ==========================================================================
   // Tests
   initial begin
      #200_000;
      n_fail++;
      summarize();
   end
   initial begin
      logic [31:0] c, s;
      logic        g, r;
      int          n0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      xfer(1'b0, OFF_SEQ_PARAMS, 0);
      chk("seq_params_rst", {22'h0, RST_SEQ_PARAMS}, rd);
      xfer(1'b0, 8'h20, 0);
      chk("unmapped_err", 1, err);
      wr(OFF_SUPPLY_IND, 1);
      chk("ro_write_err", 1, err);
      wr(OFF_COMMAND_GATE, 0);
      wr(OFF_COMMAND_WORD, 32'hffff_ffff);
      xfer(1'b0, OFF_COMMAND_WORD, 0);
      chk("word_range", {16'h0, COMMAND_WORD_MAX}, rd);
      $display("test registers done");
      for (int i = 0; i < 40; i++) begin
         c = rnd() & 32'h0000_03ff;
         s = rnd();
         g = s[20];
         r = s[21] && i > 1;
         s &= 32'h0000_00ff;
         if (i < 2) begin
            g = 1'b1;
            c = 32'h0000_03ff ^ (i << 7);
         end
         @(posedge clk_sys);
         regen_mode <= r;
         wr(OFF_SEQ_PARAMS, s);
         wr(OFF_COMMAND_WORD, c);
         wr(OFF_COMMAND_GATE, {31'h0, g});
         cyc(3);
         chk("drive_enable", exp_seq(g, c, s) & 8'h01, seq_out & 8'h01);
         if (!r) chk("sequencing", exp_seq(g, c, s), seq_out);
         if (g && !r) chk("ref_select", c[8], reference_select);
         xfer(1'b0, OFF_SEQ_PARAMS, 0);
         chk("params_kept", s, rd & 32'h0000_00ff);
      end
      @(posedge clk_sys);
      regen_mode <= 1'b0;
      $display("test decode done");
      wr(OFF_COMMAND_GATE, 1);
      wr(OFF_COMMAND_WORD, 32'h0000_1000);
      cyc(3);
      chk("cw_trip", 1, command_word_trip);
      n_rst = 0;
      wr(OFF_COMMAND_WORD, 32'h0000_3000);
      cyc(10);
      chk("trip_held", 1, command_word_trip);
      chk("reset_count", 1, n_rst);
      wr(OFF_COMMAND_WORD, 0);
      wr(OFF_COMMAND_WORD, 32'h0000_2000);
      cyc(10);
      chk("trip_cleared", 0, command_word_trip);
      chk("reset_count", 2, n_rst);
      xfer(1'b0, OFF_SEQ_PARAMS, 0);
      chk("reset_param", 0, rd & 32'h0000_0200);
      wr(OFF_COMMAND_WORD, 0);
      wr(OFF_COMMAND_GATE, 0);
      wr(OFF_COMMAND_WORD, 32'h0000_2000);
      cyc(5);
      chk("ungated_reset", 2, n_rst);
      wr(OFF_COMMAND_GATE, 1);
      cyc(5);
      chk("regated_reset", 3, n_rst);
      wr(OFF_COMMAND_WORD, 0);
      $display("test trip_reset done");
      for (int i = 0; i < 4; i++) begin
         wr(OFF_COMMAND_WORD, 32'h0000_4000);
         cyc(25);
         wr(OFF_COMMAND_WORD, 0);
      end
      chk("wdog_serviced", 0, keypad_watchdog_trip);
      cyc(70);
      chk("wdog_trip", 1, keypad_watchdog_trip);
      wr(OFF_COMMAND_WORD, 32'h0000_2000);
      cyc(5);
      chk("wdog_reset", 0, keypad_watchdog_trip);
      wr(OFF_COMMAND_WORD, 0);
      cyc(70);
      chk("wdog_disarmed", 0, keypad_watchdog_trip);
      wr(OFF_COMMAND_WORD, 32'h0000_4000);
      cyc(70);
      chk("wdog_rearmed", 1, keypad_watchdog_trip);
      wr(OFF_COMMAND_GATE, 0);
      $display("test watchdog done");
      @(posedge clk_sys);
      mode_change_done <= 1'b1;
      @(posedge clk_sys);
      mode_change_done <= 1'b0;
      cyc(20);
      xfer(1'b0, OFF_EVENT_FLAGS, 0);
      chk("mode_flag", 32'h0000_0002, rd);
      wr(OFF_EVENT_FLAGS, 32'h0000_0002);
      xfer(1'b0, OFF_EVENT_FLAGS, 0);
      chk("mode_flag_clr", 0, rd);
      $display("test events done");
      supply(1'b1, 1'b1);
      supply(1'b0, 1'b1);
      xfer(1'b0, OFF_SUPPLY_IND, 0);
      chk("battery_ind", 1, rd);
      n0 = n_save;
      supply(1'b1, 1'b0);
      chk("no_save_battery", n0, n_save);
      supply(1'b0, 1'b0);
      xfer(1'b0, OFF_SUPPLY_IND, 0);
      chk("mains_ind", 0, rd);
      supply(1'b1, 1'b0);
      chk("save_mains", n0 + 1, n_save);
      $display("test supply done");
      summarize();
   end
endmodule
